// >>> rtl/csm_clock_switch.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "csm_map.svh"

module csm_clock_switch (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [1:0] switch_monitor_select,
    input wire csm_pkg::csm_group_type initial_osc_group,
    input wire logic [4:0] primary_osc_mode,
    input wire logic power_up_timer_done,
    input wire logic sleep_mode,
    input wire logic watchdog_cfg_en,
    input wire logic soft_watchdog_enable,
    input wire logic sys_osc_edge,
    input wire logic low_power_rc_osc_tick,
    input wire logic pll_lock_in,
    output logic low_power_rc_osc_en,
    output csm_pkg::csm_group_type osc_group_sel,
    output logic [4:0] primary_mode_sel,
    output logic clk_fail_trap,
    output logic [3:0] rc_trim_out,
    output logic irq
);
    import csm_pkg::*;

    csm_state_type state_reg;
    csm_group_type current_osc_group_reg;
    csm_group_type new_osc_group_reg;
    logic switch_enable_bit_reg;
    logic clock_fail_flag_reg;
    logic pll_lock_reg;
    logic [3:0] rc_trim_field_reg;
    logic [7:0] settle_reg;
    logic [`CSM_EV_W-1:0] ev_status_reg;
    logic [`CSM_EV_W-1:0] ev_mask_reg;
    logic [`CSM_EV_W-1:0] ev_set;
    logic switching_on;
    logic monitor_on;
    logic fail_pulse;
    logic fail_take;
    logic start_req;
    logic switch_done;
    logic watch_en;
    logic wr_ctrl;
    logic rd_status;
    logic [15:0] ctrl_word;

    // configuration decode: 1x turns both functions off
    assign switching_on = ~switch_monitor_select[1];
    assign monitor_on = switch_monitor_select == `CSM_SMS_BOTH;

    // watch the running oscillator; fast RC is the fallback and is not watched.
    // watching starts once the power-up timer ends, so a slow starter traps
    assign watch_en = monitor_on && power_up_timer_done && !sleep_mode
        && current_osc_group_reg != `CSM_GRP_FAST_RC
        && (state_reg == ST_IDLE || state_reg == ST_SWITCH);

    csm_fail_window u_fail_window (
        .ref_clk(ref_clk),
        .rst(rst),
        .watch_en(watch_en),
        .sys_osc_edge(sys_osc_edge),
        .low_power_rc_osc_tick(low_power_rc_osc_tick),
        .fail_pulse(fail_pulse)
    );

    // a failure outranks any software switch in flight
    assign fail_take = fail_pulse && (state_reg == ST_IDLE || state_reg == ST_SWITCH);
    assign start_req = state_reg == ST_IDLE && !fail_pulse && switch_enable_bit_reg && switching_on
        && csm_group_valid(new_osc_group_reg) && new_osc_group_reg != current_osc_group_reg;
    assign switch_done = state_reg == ST_SWITCH && !fail_pulse && switch_enable_bit_reg
        && settle_reg == 8'(`CSM_SWITCH_CYC - 1);
    assign wr_ctrl = reg_wr && reg_addr == `CSM_ADDR_OSC_CTRL;
    assign rd_status = reg_rd && reg_addr == `CSM_ADDR_EV_STATUS;

    // sequencer: switch settle wait, or the three failure steps in order
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (fail_take) begin
                        state_reg <= ST_FAIL_LOAD;
                    end else if (start_req) begin
                        state_reg <= ST_SWITCH;
                    end
                end
                ST_SWITCH: begin
                    if (fail_take) begin
                        state_reg <= ST_FAIL_LOAD;
                    end else if (!switch_enable_bit_reg || !switching_on || switch_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_FAIL_LOAD: state_reg <= ST_FAIL_FLAG;
                ST_FAIL_FLAG: state_reg <= ST_FAIL_DROP;
                ST_FAIL_DROP: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // settle counter for a software switch
    always_ff @(posedge ref_clk) begin
        if (rst || state_reg != ST_SWITCH) begin
            settle_reg <= 8'h00;
        end else begin
            settle_reg <= settle_reg + 8'h01;
        end
    end

    // current group: configuration when switching is off, else the sequencer
    always_ff @(posedge ref_clk) begin
        if (rst || !switching_on) begin
            current_osc_group_reg <= initial_osc_group;
        end else if (state_reg == ST_FAIL_LOAD) begin
            current_osc_group_reg <= `CSM_GRP_FAST_RC;
        end else if (switch_done) begin
            current_osc_group_reg <= new_osc_group_reg;
        end
    end

    // new group: written by software, illegal codes ignored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            new_osc_group_reg <= initial_osc_group;
        end else if (wr_ctrl && csm_group_valid(reg_wdata[`CSM_NEW_MSB:`CSM_NEW_LSB])) begin
            new_osc_group_reg <= reg_wdata[`CSM_NEW_MSB:`CSM_NEW_LSB];
        end
    end

    // enable bit: hardware clears on failure, completion or nothing to do;
    // the failure and completion clears win over a write, so a stale write cannot restart a dead switch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            switch_enable_bit_reg <= 1'b0;
        end else if (state_reg == ST_FAIL_DROP || switch_done) begin
            switch_enable_bit_reg <= 1'b0;
        end else if (wr_ctrl && switching_on) begin
            switch_enable_bit_reg <= reg_wdata[`CSM_SWEN_BIT];
        end else if (state_reg == ST_IDLE && switch_enable_bit_reg && !start_req && !fail_pulse) begin
            switch_enable_bit_reg <= 1'b0;
        end
    end

    // failure flag: set in step two, cleared by a later good switch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clock_fail_flag_reg <= 1'b0;
        end else if (state_reg == ST_FAIL_FLAG) begin
            clock_fail_flag_reg <= 1'b1;
        end else if (switch_done) begin
            clock_fail_flag_reg <= 1'b0;
        end
    end

    // trap strobe for the core, one cycle per accepted failure
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_fail_trap <= 1'b0;
        end else begin
            clk_fail_trap <= fail_take;
        end
    end

    // slow RC enable: forced on until the power-up timer ends
    always_ff @(posedge ref_clk) begin
        if (rst || !power_up_timer_done) begin
            low_power_rc_osc_en <= 1'b1;
        end else if (monitor_on) begin
            low_power_rc_osc_en <= !sleep_mode;
        end else begin
            low_power_rc_osc_en <= watchdog_cfg_en || soft_watchdog_enable
                || current_osc_group_reg == `CSM_GRP_LOW_POWER;
        end
    end

    // clock mux selection; the primary option always follows configuration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_group_sel <= `CSM_GRP_SECONDARY;
            primary_mode_sel <= 5'h00;
        end else begin
            osc_group_sel <= current_osc_group_reg;
            primary_mode_sel <= primary_osc_mode;
        end
    end

    // lock status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pll_lock_reg <= 1'b0;
        end else begin
            pll_lock_reg <= pll_lock_in;
        end
    end

    // trim field, signed two's complement around the calibrated centre
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rc_trim_field_reg <= `CSM_TRIM_RESET;
        end else if (reg_wr && reg_addr == `CSM_ADDR_RC_TUNE) begin
            rc_trim_field_reg <= reg_wdata[`CSM_TRIM_MSB:0];
        end
    end

    assign rc_trim_out = rc_trim_field_reg;

    // event sources
    always_comb begin
        ev_set = '0;
        ev_set[`CSM_EV_FAIL] = state_reg == ST_FAIL_FLAG;
        ev_set[`CSM_EV_DONE] = switch_done;
        ev_set[`CSM_EV_LOCK] = pll_lock_in && !pll_lock_reg;
    end

    // sticky events: read clears, a same-cycle event survives the read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ev_status_reg <= '0;
        end else begin
            ev_status_reg <= (rd_status ? '0 : ev_status_reg) | ev_set;
        end
    end

    // interrupt mask, same layout as the status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ev_mask_reg <= '0;
        end else if (reg_wr && reg_addr == `CSM_ADDR_EV_MASK) begin
            ev_mask_reg <= reg_wdata[`CSM_EV_W-1:0];
        end
    end

    // level interrupt, one cycle behind the status so it comes from a flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_status_reg & ev_mask_reg);
        end
    end

    // control word image
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[`CSM_CUR_MSB:`CSM_CUR_LSB] = current_osc_group_reg;
        ctrl_word[`CSM_NEW_MSB:`CSM_NEW_LSB] = new_osc_group_reg;
        ctrl_word[`CSM_LOCK_BIT] = pll_lock_reg;
        ctrl_word[`CSM_FAIL_BIT] = clock_fail_flag_reg;
        ctrl_word[`CSM_SWEN_BIT] = switch_enable_bit_reg;
    end

    // read data stand one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            unique case (reg_addr)
                `CSM_ADDR_OSC_CTRL: reg_rdata <= ctrl_word;
                `CSM_ADDR_RC_TUNE: reg_rdata <= {12'h000, rc_trim_field_reg};
                `CSM_ADDR_EV_STATUS: reg_rdata <= {13'h0000, ev_status_reg};
                `CSM_ADDR_EV_MASK: reg_rdata <= {13'h0000, ev_mask_reg};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    // checks on the sequencer, the slow RC enable and the register fields; reset masks them all
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_fail_steps_order: assert property (fail_take |=> state_reg == ST_FAIL_LOAD
        ##1 current_osc_group_reg == `CSM_GRP_FAST_RC && !clock_fail_flag_reg
        ##1 clock_fail_flag_reg ##1 !switch_enable_bit_reg)
        else $error("failure steps out of order");

    a_fail_trap_pulse: assert property (fail_take |=> clk_fail_trap ##1 !clk_fail_trap)
        else $error("trap strobe missing or too long");

    a_low_power_rc_osc_boot_on: assert property (!power_up_timer_done |=> low_power_rc_osc_en)
        else $error("slow RC off before power-up timer end");

    a_low_power_rc_osc_monitor_on: assert property (monitor_on && power_up_timer_done && !sleep_mode
        && $stable(monitor_on) |=> low_power_rc_osc_en)
        else $error("slow RC off with monitor on");

    a_low_power_rc_osc_shut_off: assert property (power_up_timer_done && !monitor_on && !watchdog_cfg_en
        && !soft_watchdog_enable && current_osc_group_reg != `CSM_GRP_LOW_POWER |=> !low_power_rc_osc_en)
        else $error("slow RC left running");

    a_wdt_clock_kept: assert property (watchdog_cfg_en && !sleep_mode |=> low_power_rc_osc_en)
        else $error("watchdog clock stopped");

    a_switch_abort: assert property (state_reg == ST_SWITCH && !switch_enable_bit_reg && !fail_pulse
        |=> state_reg == ST_IDLE && $stable(current_osc_group_reg))
        else $error("abort did not stop the switch");

    a_cfg_direct_sel: assert property (!switching_on && !$past(switching_on)
        |-> current_osc_group_reg == $past(initial_osc_group) && state_reg != ST_SWITCH)
        else $error("group not following configuration");

    a_tune_upper_zero: assert property (reg_rd && reg_addr == `CSM_ADDR_RC_TUNE
        |=> reg_rdata == {12'h000, $past(rc_trim_field_reg)})
        else $error("tuning read wrong");

    a_low_power_rc_osc_sleep_off: assert property (monitor_on && power_up_timer_done && sleep_mode
        |=> !low_power_rc_osc_en)
        else $error("slow RC left running in Sleep");

    a_new_group_legal: assert property (wr_ctrl && !csm_group_valid(reg_wdata[`CSM_NEW_MSB:`CSM_NEW_LSB])
        |=> $stable(new_osc_group_reg))
        else $error("illegal group code taken");

    c_fail_seen: cover property (fail_take ##4 state_reg == ST_IDLE);
    c_switch_done: cover property (start_req ##[1:20] switch_done);
    c_switch_abort: cover property (state_reg == ST_SWITCH ##1 !switch_enable_bit_reg);
    c_lock_event: cover property (ev_set[`CSM_EV_LOCK] ##2 irq);
    c_slow_start: cover property (!power_up_timer_done ##1 power_up_timer_done ##[1:200] fail_take);
endmodule

// >>> rtl/csm_map.svh
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH

// register word offsets on the plain port
`define CSM_ADDR_OSC_CTRL 4'h0
`define CSM_ADDR_RC_TUNE 4'h1
`define CSM_ADDR_EV_STATUS 4'h2
`define CSM_ADDR_EV_MASK 4'h3

// osc_control_reg field positions
`define CSM_CUR_MSB 14
`define CSM_CUR_LSB 12
`define CSM_NEW_MSB 10
`define CSM_NEW_LSB 8
`define CSM_LOCK_BIT 5
`define CSM_FAIL_BIT 3
`define CSM_SWEN_BIT 0

// rc_tuning_reg field
`define CSM_TRIM_MSB 3
`define CSM_TRIM_RESET 4'h0

// oscillator group codes
`define CSM_GRP_SECONDARY 3'h0
`define CSM_GRP_FAST_RC 3'h1
`define CSM_GRP_LOW_POWER 3'h2
`define CSM_GRP_PRIMARY 3'h3

// switch_monitor_select: 1x disables both, 01 switching only, 00 both
`define CSM_SMS_BOTH 2'h0

// event bits
`define CSM_EV_FAIL 0
`define CSM_EV_DONE 1
`define CSM_EV_LOCK 2
`define CSM_EV_W 3

// timing
`define CSM_CLK_PERIOD_NS 4
`define CSM_SWITCH_NS 40
`define CSM_SWITCH_CYC (`CSM_SWITCH_NS / `CSM_CLK_PERIOD_NS)
`define CSM_FAIL_TICKS 8'h04

`endif

// >>> rtl/csm_pkg.sv
package csm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SWITCH = 3'b001,
        ST_FAIL_LOAD = 3'b010,
        ST_FAIL_FLAG = 3'b011,
        ST_FAIL_DROP = 3'b100
    } csm_state_type;

    typedef logic [2:0] csm_group_type;

    // only the four group codes are legal selections
    function automatic logic csm_group_valid(input csm_group_type g);
        return (g == 3'h0) || (g == 3'h1) || (g == 3'h2) || (g == 3'h3);
    endfunction

endpackage

// >>> rtl/csm_fail_window.sv
`timescale 1ns/1ps
`include "csm_map.svh"

module csm_fail_window (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic watch_en,
    input wire logic sys_osc_edge,
    input wire logic low_power_rc_osc_tick,
    output logic fail_pulse
);
    logic [7:0] gap_reg;
    logic [7:0] gap_next;

    // count slow ticks since the last system oscillator edge
    always_comb begin
        gap_next = gap_reg;
        if (!watch_en || sys_osc_edge) begin
            gap_next = 8'h00;
        end else if (low_power_rc_osc_tick && gap_reg != `CSM_FAIL_TICKS) begin
            gap_next = gap_reg + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gap_reg <= 8'h00;
        end else begin
            gap_reg <= gap_next;
        end
    end

    // one pulse when the window closes with no edge seen
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fail_pulse <= 1'b0;
        end else begin
            fail_pulse <= watch_en && gap_next == `CSM_FAIL_TICKS && gap_reg != `CSM_FAIL_TICKS;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_fail_window: assert property (fail_pulse |-> gap_reg == `CSM_FAIL_TICKS
        && $past(gap_reg) != `CSM_FAIL_TICKS && $past(watch_en))
        else $error("failure pulse without a full silent window");
endmodule

// >>> testbench/csm_osc_model.sv
`timescale 1ns/1ps

// oscillator sources: system oscillator edges and slow RC ticks
module csm_osc_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic osc_run,
    output logic sys_osc_edge,
    output logic low_power_rc_osc_tick
);
    logic [3:0] phase_reg;

    // free running phase, slow RC ticks once every 16 cycles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end

    // system oscillator edge every other cycle, far above the slowest legal clock
    always_ff @(posedge ref_clk) begin
        sys_osc_edge <= !rst && osc_run && phase_reg[0];
        low_power_rc_osc_tick <= !rst && (phase_reg == 4'hF);
    end
endmodule

// >>> testbench/clock_switch_failsafe_monitor_test.sv
`timescale 1ns/1ps
`include "csm_map.svh"

module clock_switch_failsafe_monitor_test;
    import csm_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] switch_monitor_select = 2'h2;
    csm_group_type initial_osc_group = 3'h2;
    logic [4:0] primary_osc_mode = 5'h0B;
    logic power_up_timer_done = 1'b0;
    logic sleep_mode = 1'b0;
    logic watchdog_cfg_en = 1'b0;
    logic soft_watchdog_enable = 1'b0;
    logic pll_lock_in = 1'b0;
    logic osc_run = 1'b1;
    logic sys_osc_edge, low_power_rc_osc_tick, low_power_rc_osc_en, clk_fail_trap, irq;
    csm_group_type osc_group_sel;
    logic [4:0] primary_mode_sel;
    logic [3:0] rc_trim_out;
    logic [15:0] rd;
    int n_fail = 0;
    int checks = 0;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    csm_clock_switch uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .switch_monitor_select(switch_monitor_select),
        .initial_osc_group(initial_osc_group), .primary_osc_mode(primary_osc_mode),
        .power_up_timer_done(power_up_timer_done), .sleep_mode(sleep_mode), .watchdog_cfg_en(watchdog_cfg_en),
        .soft_watchdog_enable(soft_watchdog_enable), .sys_osc_edge(sys_osc_edge), .low_power_rc_osc_tick(low_power_rc_osc_tick),
        .pll_lock_in(pll_lock_in), .low_power_rc_osc_en(low_power_rc_osc_en), .osc_group_sel(osc_group_sel),
        .primary_mode_sel(primary_mode_sel), .clk_fail_trap(clk_fail_trap), .rc_trim_out(rc_trim_out), .irq(irq));

    csm_osc_model osc (.ref_clk(ref_clk), .rst(rst), .osc_run(osc_run), .sys_osc_edge(sys_osc_edge),
        .low_power_rc_osc_tick(low_power_rc_osc_tick));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // wait n edges, then step past the edge so outputs have settled
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rdr(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // cut a hang short well beyond the expected run length
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end

    initial begin
        // reset stands for twelve rising edges
        tick(11);
        chk(16'(low_power_rc_osc_en), 16'h0001);
        @(posedge ref_clk);
        rst <= 1'b0;
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd, 16'h2200);
        rdr(`CSM_ADDR_RC_TUNE);
        chk(rd, 16'h0000);
        // switching disabled: enable write is ignored, configuration drives the mux
        @(posedge ref_clk);
        power_up_timer_done <= 1'b1;
        wr(`CSM_ADDR_OSC_CTRL, 16'h0301);
        tick(14);
        chk(16'(low_power_rc_osc_en), 16'h0001);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd & 16'h7001, 16'h2000);
        chk(16'(osc_group_sel), 16'h0002);
        // trim codes at both extremes, and an unmapped address reading zero
        wr(`CSM_ADDR_RC_TUNE, 16'hFFF7);
        rdr(`CSM_ADDR_RC_TUNE);
        chk(rd, 16'h0007);
        chk(16'(rc_trim_out), 16'h0007);
        wr(`CSM_ADDR_RC_TUNE, 16'h0008);
        rdr(`CSM_ADDR_RC_TUNE);
        chk(rd, 16'h0008);
        chk(16'(rc_trim_out), 16'h0008);
        rdr(4'hF);
        chk(rd, 16'h0000);
        // software switch to primary with switching only
        @(posedge ref_clk);
        switch_monitor_select <= 2'h1;
        wr(`CSM_ADDR_EV_MASK, 16'h0007);
        rdr(`CSM_ADDR_EV_MASK);
        chk(rd, 16'h0007);
        wr(`CSM_ADDR_OSC_CTRL, 16'h0300);
        wr(`CSM_ADDR_OSC_CTRL, 16'h0301);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd & 16'h0001, 16'h0001);
        tick(14);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd, 16'h3300);
        chk(16'(osc_group_sel), 16'h0003);
        chk(16'(primary_mode_sel), 16'h000B);
        chk(16'(irq), 16'h0001);
        chk(16'(low_power_rc_osc_en), 16'h0000);
        rdr(`CSM_ADDR_EV_STATUS);
        chk(rd, 16'h0002);
        tick(2);
        chk(16'(irq), 16'h0000);
        @(posedge ref_clk);
        watchdog_cfg_en <= 1'b1;
        tick(3);
        chk(16'(low_power_rc_osc_en), 16'h0001);
        @(posedge ref_clk);
        watchdog_cfg_en <= 1'b0;
        // clearing the enable mid-switch aborts it
        wr(`CSM_ADDR_OSC_CTRL, 16'h0200);
        wr(`CSM_ADDR_OSC_CTRL, 16'h0201);
        wr(`CSM_ADDR_OSC_CTRL, 16'h0200);
        tick(14);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd, 16'h3200);
        chk(16'(osc_group_sel), 16'h0003);
        // monitor on: slow RC runs whatever the software enable says, except in Sleep
        @(posedge ref_clk);
        switch_monitor_select <= 2'h0;
        tick(3);
        chk(16'(low_power_rc_osc_en), 16'h0001);
        @(posedge ref_clk);
        sleep_mode <= 1'b1;
        soft_watchdog_enable <= 1'b1;
        tick(3);
        chk(16'(low_power_rc_osc_en), 16'h0000);
        @(posedge ref_clk);
        sleep_mode <= 1'b0;
        soft_watchdog_enable <= 1'b0;
        // lock event masked, then unmasked, then cleared by reading
        wr(`CSM_ADDR_EV_MASK, 16'h0000);
        rdr(`CSM_ADDR_EV_STATUS);
        @(posedge ref_clk);
        pll_lock_in <= 1'b1;
        tick(4);
        chk(16'(irq), 16'h0000);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd & 16'h0020, 16'h0020);
        wr(`CSM_ADDR_EV_MASK, 16'h0007);
        tick(2);
        chk(16'(irq), 16'h0001);
        rdr(`CSM_ADDR_EV_STATUS);
        chk(rd, 16'h0004);
        tick(2);
        chk(16'(irq), 16'h0000);
        // system oscillator dies: trap, forced move to fast RC
        @(posedge ref_clk);
        osc_run <= 1'b0;
        tick(1);
        for (int i = 0; i < 300 && clk_fail_trap !== 1'b1; i++) begin
            tick(1);
        end
        chk(16'(clk_fail_trap), 16'h0001);
        tick(4);
        chk(16'(osc_group_sel), 16'h0001);
        chk(16'(low_power_rc_osc_en), 16'h0001);
        chk(16'(irq), 16'h0001);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd & 16'h7009, 16'h1008);
        rdr(`CSM_ADDR_EV_STATUS);
        chk(rd & 16'h0001, 16'h0001);
        // second reset with primary as boot group; the oscillator never starts
        @(posedge ref_clk);
        rst <= 1'b1;
        power_up_timer_done <= 1'b0;
        initial_osc_group <= 3'h3;
        tick(4);
        chk(16'(low_power_rc_osc_en), 16'h0001);
        @(posedge ref_clk);
        rst <= 1'b0;
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd & 16'h7709, 16'h3300);
        // an illegal group code is refused and the enable falls back at once
        wr(`CSM_ADDR_OSC_CTRL, 16'h0701);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd & 16'h7709, 16'h3300);
        @(posedge ref_clk);
        power_up_timer_done <= 1'b1;
        for (int i = 0; i < 300 && clk_fail_trap !== 1'b1; i++) begin
            tick(1);
        end
        chk(16'(clk_fail_trap), 16'h0001);
        tick(4);
        chk(16'(osc_group_sel), 16'h0001);
        rdr(`CSM_ADDR_OSC_CTRL);
        chk(rd & 16'h7009, 16'h1008);
        print_verdict();
    end
endmodule
